// file: logic/response_defines.svh
`ifndef RESPONSE_DEFINES_SVH
`define RESPONSE_DEFINES_SVH
// Function
// - in completion with data pending, reading a byte other than the last returns it and changes nothing else.
// - reading the last response byte clears the response available flag and stays in completion.
// - a retry-only status write in completion rewinds the read pointer and sets the available flag.
// - an execute go request in completion with no data pending is ignored.
// - a command-ready-only status write in completion moves to idle with the available flag cleared and sets the idle interrupt flag.
// - data port writes in completion with no data pending are dropped.
// - a data port read while the available flag is clear returns FFh and changes nothing.
// - when execution finishes the device enters completion and sets the available flag.
// - an execute go request in completion with data pending causes no change.
// - data port writes in completion with data pending have no effect.

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_STATUS 8'h00
`define REG_DATA 8'h04
`define REG_LENGTH 8'h08
`define REG_IRQ_STATUS 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_CONTROL 8'h14
// ----------------------------------------
// status register fields
// ----------------------------------------
`define STS_RETRY_BIT 1
`define STS_AVAIL_BIT 4
`define STS_GO_BIT 5
`define STS_READY_BIT 6
// ----------------------------------------
// interrupt bits, empty read value and response codes
// ----------------------------------------
`define IRQ_DONE_BIT 0
`define IRQ_DRAINED_BIT 1
`define IRQ_IDLE_BIT 2
`define IRQ_WIDTH 3
`define EMPTY_READ 8'hFF
`define RESP_AXI_OKAY 2'b00
`define RESP_AXI_SLVERR 2'b10
`endif

// file: logic/response_pkg.sv
package response_pkg;
	typedef enum logic [1:0] {st_idle, st_execution, st_completion} phase_type;
endpackage

// file: logic/response_queue.sv
`timescale 1ns/10ps
// response byte store with a rewindable read pointer
module response_queue #(
	parameter int depth = 64,
	parameter int aw = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load_valid,
	input wire logic [7:0] load_data,
	input wire logic [aw-1:0] load_addr,
	input wire logic rewind,
	input wire logic advance,
	output logic [aw-1:0] pointer,
	output logic [7:0] head
);
	logic [7:0] mem [depth];

	always_ff @(posedge aclk) begin
		if (load_valid) begin
			mem[load_addr] <= load_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || rewind) begin
			pointer <= '0;
		end else if (advance) begin
			pointer <= pointer + aw'(1);
		end
	end

	assign head = mem[pointer];
endmodule

// file: logic/response_control.sv
`timescale 1ns/10ps
`include "response_defines.svh"
module response_control #(
	parameter int depth = 64,
	parameter int aw = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic exec_done,
	input wire logic load_valid,
	input wire logic [7:0] load_data,
	input wire logic [aw-1:0] load_addr,
	output logic irq
);
	response_pkg::phase_type phase;
	logic avail;
	logic [aw:0] length;
	logic [`IRQ_WIDTH-1:0] irq_status;
	logic [`IRQ_WIDTH-1:0] irq_mask;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [aw-1:0] pointer;
	logic [7:0] head;

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire wr_status = wr_fire && aw_addr == `REG_STATUS;
	wire wr_data = wr_fire && aw_addr == `REG_DATA;
	wire wr_length = wr_fire && aw_addr == `REG_LENGTH;
	wire wr_irq_sts = wr_fire && aw_addr == `REG_IRQ_STATUS;
	wire wr_irq_mask = wr_fire && aw_addr == `REG_IRQ_MASK;
	wire wr_known = wr_status || wr_data || wr_length || wr_irq_sts || wr_irq_mask;
	wire [2:0] cmd_bits = {w_data[`STS_READY_BIT], w_data[`STS_GO_BIT], w_data[`STS_RETRY_BIT]};
	wire in_completion = phase == response_pkg::st_completion;
	// several fields set at once is left undefined; this block acts on none of them
	wire cmd_retry = wr_status && cmd_bits == 3'h1 && in_completion;
	wire cmd_ready = wr_status && cmd_bits == 3'h4 && in_completion;
	// the go request only starts execution from idle; it is how a command is begun here
	wire wr_control_go = wr_status && cmd_bits == 3'h2 && phase == response_pkg::st_idle;
	// go never changes anything in completion
	// data writes are always dropped here; nothing accepts a command

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_data = rd_take && s_axi_araddr == `REG_DATA;
	wire pop = rd_data && avail && in_completion;
	wire last_byte = {1'b0, pointer} == length - (aw+1)'(1);
	wire drained = pop && last_byte;
	wire start_done = exec_done && phase == response_pkg::st_execution;
	wire [31:0] status_word = 32'(avail) << `STS_AVAIL_BIT;
	wire [31:0] data_word = avail ? {24'h000000, head} : {24'h000000, `EMPTY_READ};
	wire [31:0] rd_word = s_axi_araddr == `REG_STATUS ? status_word :
		s_axi_araddr == `REG_DATA ? data_word :
		s_axi_araddr == `REG_LENGTH ? 32'(length) :
		s_axi_araddr == `REG_IRQ_STATUS ? 32'(irq_status) :
		s_axi_araddr == `REG_IRQ_MASK ? 32'(irq_mask) :
		s_axi_araddr == `REG_CONTROL ? 32'(phase) : 32'h00000000;
	wire rd_known = s_axi_araddr <= `REG_CONTROL && s_axi_araddr[1:0] == 2'b00;
	wire [`IRQ_WIDTH-1:0] irq_events = {cmd_ready, drained, start_done};

	response_queue #(.depth(depth), .aw(aw)) queue (
		.aclk(aclk),
		.aresetn(aresetn),
		.load_valid(load_valid),
		.load_data(load_data),
		.load_addr(load_addr),
		.rewind(cmd_retry || start_done),
		.advance(pop),
		.pointer(pointer),
		.head(head)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_AXI_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
		end else begin
			s_axi_awready <= !aw_held && !aw_take;
			s_axi_wready <= !w_held && !w_take;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `RESP_AXI_OKAY : `RESP_AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_AXI_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? `RESP_AXI_OKAY : `RESP_AXI_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	// ----------------------------------------
	// phase and flags
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= response_pkg::st_idle;
			avail <= 1'b0;
			length <= '0;
		end else begin
			if (wr_length && phase != response_pkg::st_completion) begin
				length <= w_data[aw:0];
			end
			if (start_done) begin
				phase <= response_pkg::st_completion;
				avail <= 1'b1;
			end else if (cmd_ready) begin
				phase <= response_pkg::st_idle;
				avail <= 1'b0;
			end else if (cmd_retry) begin
				avail <= 1'b1;
			end else if (drained) begin
				avail <= 1'b0;
			end else if (wr_control_go) begin
				phase <= response_pkg::st_execution;
			end
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= '0;
			irq_mask <= '0;
			irq <= 1'b0;
		end else begin
			// a set in the clearing cycle wins
			irq_status <= (irq_status & ~(wr_irq_sts ? w_data[`IRQ_WIDTH-1:0] : '0)) | irq_events;
			if (wr_irq_mask) begin
				irq_mask <= w_data[`IRQ_WIDTH-1:0];
			end
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	done_enters_completion_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start_done |=> in_completion && avail) else $error("execution end did not enter completion");
	pop_keeps_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pop && !last_byte && !cmd_ready && !cmd_retry |=> in_completion && avail)
		else $error("mid read changed state");
	last_clears_avail_a: assert property (@(posedge aclk) disable iff (!aresetn)
		drained && !cmd_ready && !cmd_retry |=> in_completion && !avail) else $error("last byte kept avail");
	retry_rewinds_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_retry && !start_done |=> avail && pointer == '0) else $error("retry did not rewind");
	ready_to_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_ready && !start_done |=> phase == response_pkg::st_idle && !avail) else $error("ready did not idle");
	go_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_status && cmd_bits == 3'h2 && in_completion && !drained |=> in_completion && $stable(avail))
		else $error("go changed completion");
	data_write_dropped_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_data && in_completion && !rd_take |=> $stable(avail) && $stable(pointer))
		else $error("data write had effect");
	empty_read_ff_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_data && !avail && !cmd_retry && !start_done |=> s_axi_rdata == {24'h000000, `EMPTY_READ} && $stable(pointer))
		else $error("empty read not FF");
	ascending_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pop && !cmd_retry && !start_done |=> pointer == $past(pointer) + aw'(1)) else $error("pointer not stepped");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		|(irq_status & irq_mask) |=> irq) else $error("irq not raised");
	drain_cover: cover property (@(posedge aclk) disable iff (!aresetn) drained);
	retry_cover: cover property (@(posedge aclk) disable iff (!aresetn) cmd_retry && !avail);
	idle_cover: cover property (@(posedge aclk) disable iff (!aresetn) cmd_ready);
	empty_cover: cover property (@(posedge aclk) disable iff (!aresetn) rd_data && !avail && in_completion);
endmodule

// file: verification/response_source.sv
`timescale 1ns/10ps
// ----------------------------------------
// execution side: loads a response, then reports completion
// ----------------------------------------
module response_source #(
	parameter int count = 4,
	parameter int aw = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	output logic load_valid,
	output logic [7:0] load_data,
	output logic [aw-1:0] load_addr,
	output logic exec_done
);
	logic [aw:0] idx;
	logic busy;
	// all bytes land before the done pulse, so the device never sees a half-loaded response
	always_ff @(posedge aclk) begin
		exec_done <= 1'h0;
		load_valid <= 1'h0;
		if (!aresetn) begin
			busy <= 1'h0;
			idx <= '0;
			load_data <= 8'h00;
			load_addr <= '0;
		end else if (start) begin
			busy <= 1'h1;
			idx <= '0;
		end else if (busy && idx < count) begin
			load_valid <= 1'h1;
			load_addr <= idx[aw-1:0];
			load_data <= 8'hA0 + 8'(idx);
			idx <= idx + 1'h1;
		end else if (busy) begin
			busy <= 1'h0;
			exec_done <= 1'h1;
		end
	end
endmodule

// file: verification/tb.sv
`timescale 1ns/10ps
`include "response_defines.svh"
module tb;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic start = 1'h0;
	wire logic awready, wready, bvalid, arready, rvalid, irq, load_valid, exec_done;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] load_data;
	wire logic [5:0] load_addr;
	logic [1:0] resp;
	logic [31:0] val;
	int err_count = 0;
	int tests_run = 0;
	always #5 aclk = ~aclk;
	response_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .exec_done(exec_done),
		.load_valid(load_valid), .load_data(load_data), .load_addr(load_addr), .irq(irq));
	response_source src (.aclk(aclk), .aresetn(aresetn), .start(start), .load_valid(load_valid),
		.load_data(load_data), .load_addr(load_addr), .exec_done(exec_done));
	// ----------------------------------------
	// bus tasks and checks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// address and data go out together; each drops on its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid) begin
				val = rdata;
				resp = rresp;
				rready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(name, exp, val);
	endtask
	task automatic st(input logic av, input logic [1:0] ph);
		rd(`REG_STATUS);
		chk("avail", {31'h0, av}, {31'h0, val[`STS_AVAIL_BIT]});
		rc("phase", `REG_CONTROL, {30'h0, ph});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		st(1'h0, response_pkg::st_idle);
		rc("idle read", `REG_DATA, {24'h0, `EMPTY_READ});
		chk("read resp ok", {30'h0, `RESP_AXI_OKAY}, {30'h0, resp});
		wr(`REG_LENGTH, 32'h4);
		chk("write resp ok", {30'h0, `RESP_AXI_OKAY}, {30'h0, resp});
		wr(`REG_IRQ_MASK, 32'h7);
		wr(`REG_STATUS, 32'h20);
		st(1'h0, response_pkg::st_execution);
		rc("exec read", `REG_DATA, {24'h0, `EMPTY_READ});
		start <= 1'h1;
		@(posedge aclk);
		start <= 1'h0;
		while (exec_done !== 1'h1) @(posedge aclk);
		st(1'h1, response_pkg::st_completion);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`REG_STATUS, 32'h20);
		wr(`REG_DATA, 32'h55);
		for (int i = 0; i < 4; i++) begin
			rc("byte", `REG_DATA, 32'hA0 + i);
			st(i < 3, response_pkg::st_completion);
		end
		rc("drained read", `REG_DATA, {24'h0, `EMPTY_READ});
		wr(`REG_STATUS, 32'h20);
		wr(`REG_DATA, 32'h66);
		st(1'h0, response_pkg::st_completion);
		rc("irq status", `REG_IRQ_STATUS, 32'h3);
		wr(`REG_IRQ_STATUS, 32'h3);
		rc("irq cleared", `REG_IRQ_STATUS, 32'h0);
		chk("irq low", 32'h0, {31'h0, irq});
		wr(`REG_STATUS, 32'h02);
		st(1'h1, response_pkg::st_completion);
		rc("retry byte", `REG_DATA, 32'hA0);
		rc("retry byte", `REG_DATA, 32'hA1);
		wr(`REG_STATUS, 32'h02);
		rc("rewound byte", `REG_DATA, 32'hA0);
		wr(`REG_STATUS, 32'h42);
		st(1'h1, response_pkg::st_completion);
		wr(8'h20, 32'h0);
		chk("write resp", {30'h0, `RESP_AXI_SLVERR}, {30'h0, resp});
		rd(8'h24);
		chk("read resp", {30'h0, `RESP_AXI_SLVERR}, {30'h0, resp});
		wr(`REG_IRQ_MASK, 32'h3);
		wr(`REG_STATUS, 32'h40);
		st(1'h0, response_pkg::st_idle);
		rc("idle irq", `REG_IRQ_STATUS, 32'h4);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr(`REG_IRQ_MASK, 32'h7);
		rd(`REG_IRQ_MASK);
		chk("unmasked irq", 32'h1, {31'h0, irq});
		complete_run;
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		err_count++;
		complete_run;
	end
endmodule
